// [sl_pkg.sv]
package sl_pkg;

	// ----------------------------------------
	// register map
	// ----------------------------------------
	localparam int         ADDR_W    = 9;
	localparam logic [8:0] OFS_CUR1  = 9'h025;
	localparam logic [8:0] OFS_BANK1 = 9'h026;
	localparam logic [8:0] OFS_BANK2 = 9'h027;
	localparam logic [8:0] OFS_STAT  = 9'h028;
	localparam logic [8:0] OFS_ADV_R = 9'h1d6;
	localparam logic [8:0] OFS_ADV_G = 9'h1d7;

	localparam logic [7:0] RST_CUR1  = 8'h00;
	localparam logic [7:0] RST_BANK1 = 8'h00;
	localparam logic [7:0] RST_BANK2 = 8'h00;
	localparam logic [7:0] RST_ADV   = 8'hfc;

	// ----------------------------------------
	// field positions (lsb of each field; 2 bits wide except the 6-bit advance duty)
	// ----------------------------------------
	localparam int CUR1_R1_CUR  = 0;
	localparam int CUR1_G1_CUR  = 2;
	localparam int BANK1_R2_CUR = 0;
	localparam int BANK1_R2_BLK = 6;
	localparam int BANK2_G2_CUR = 0;
	localparam int BANK2_G2_BLK = 2;
	localparam int BANK2_B2_CUR = 4;
	localparam int BANK2_B2_BLK = 6;
	localparam int ADV_BLK      = 0;
	localparam int ADV_DUTY     = 2;

	// ----------------------------------------
	// channels and codes
	// ----------------------------------------
	localparam int CH_N  = 5;
	localparam int CH_R1 = 0;
	localparam int CH_G1 = 1;
	localparam int CH_R2 = 2;
	localparam int CH_G2 = 3;
	localparam int CH_B2 = 4;

	typedef enum logic [1:0] {
		SL_BLK_NONE = 2'b00,
		SL_BLK_1S   = 2'b01,
		SL_BLK_4S   = 2'b10,
		SL_BLK_8S   = 2'b11
	} sl_blink_t;

	// current codes: 0 off, 1 8.0 mA, 2 20 mA, 3 28 mA
	localparam logic [1:0] CUR_OFF   = 2'h0;
	localparam logic [5:0] DUTY_FULL = 6'h20;

	// ----------------------------------------
	// timing
	// ----------------------------------------
	localparam int CLK_NS       = 100;
	localparam int TICK_NS      = 1000000;
	localparam int TICK_CYC     = TICK_NS / CLK_NS;
	localparam int PWM_STEP_NS  = 1000;
	localparam int PWM_STEP_CYC = PWM_STEP_NS / CLK_NS;
	localparam int BLINK_W      = 13;
	localparam logic [12:0] ON_MS  = 13'h01f4;
	localparam logic [12:0] PER1_MS = 13'h03e8;
	localparam logic [12:0] PER2_MS = 13'h0fa0;
	localparam logic [12:0] PER3_MS = 13'h1f40;

endpackage

// [sl_chan_if.sv]
`timescale 1ns/1ns
interface sl_chan_if;
	logic [1:0] blink;
	logic [1:0] cur;
	logic [5:0] duty;
	logic       ms_tick;
	logic [4:0] pwm_pos;
	logic [1:0] drive;
	logic       lit;

	modport ctrl (output blink, output cur, output duty, output ms_tick, output pwm_pos,
		input drive, input lit);
	modport chan (input blink, input cur, input duty, input ms_tick, input pwm_pos,
		output drive, output lit);
endinterface

// [sl_chan.sv]
`timescale 1ns/1ns
module sl_chan (
	// clock and reset
	input  wire logic mclk,
	input  wire logic nrst,
	// control from the register block
	sl_chan_if.chan   ch
);

	typedef struct packed {
		logic [12:0] cnt;
		logic [1:0]  last_blink;
		logic        lit;
		logic [1:0]  drive;
	} sl_chan_st_t;

	sl_chan_st_t st;
	sl_chan_st_t next_st;
	logic [12:0] period;
	logic        pwm_on;

	// ----------------------------------------
	// blink period and pwm compare
	// ----------------------------------------
	always_comb begin
		unique case (sl_pkg::sl_blink_t'(ch.blink))
			sl_pkg::SL_BLK_1S: period = sl_pkg::PER1_MS;
			sl_pkg::SL_BLK_4S: period = sl_pkg::PER2_MS;
			sl_pkg::SL_BLK_8S: period = sl_pkg::PER3_MS;
			sl_pkg::SL_BLK_NONE: period = sl_pkg::PER1_MS;
		endcase
		// codes above full scale are treated as continuous on
		pwm_on = (ch.duty >= sl_pkg::DUTY_FULL) || ({1'b0, ch.pwm_pos} < ch.duty);
	end

	always_comb begin
		next_st = st;
		next_st.last_blink = ch.blink;
		// a new blink code restarts with the on phase so the change is seen at once
		if (ch.blink != st.last_blink) begin
			next_st.cnt = '0;
		end else if (ch.ms_tick) begin
			next_st.cnt = (st.cnt >= period - 13'h0001) ? '0 : st.cnt + 13'h0001;
		end
		if (ch.blink == sl_pkg::SL_BLK_NONE) begin
			next_st.lit = pwm_on;
		end else begin
			// judged on the counter being loaded, so a restart is lit on its first cycle
			next_st.lit = (next_st.cnt < sl_pkg::ON_MS);
		end
		next_st.drive = next_st.lit ? ch.cur : sl_pkg::CUR_OFF;
	end

	always_ff @(posedge mclk) begin
		if (!nrst) begin
			st <= '0;
		end else begin
			st <= next_st;
		end
	end

	assign ch.lit   = st.lit;
	assign ch.drive = st.drive;

endmodule

// [sl_top.sv]
// How it works
// - blink code sets period, 0.5 s on
// - current code picks off, 8, 20, 28 mA
// - second bank register packs green2/blue2 fields
// - red2 blink sits in bits 7:6 before
// - unconfigured advance registers start in advance mode
// - blink code 00 hands channel to pwm
// - entering advance mode starts at full duty
// - nonzero blink code returns to normal blinking
// - six-bit duty gives on-fraction value/32, full on from 32 up
// - red1/green1 advance registers reset to 0xfc
`timescale 1ns/1ns
module sl_top #(
	parameter int TICK_CYC = sl_pkg::TICK_CYC
) (
	// clock and reset
	input  wire logic                            mclk,
	input  wire logic                            nrst,
	// register port
	input  wire logic [sl_pkg::ADDR_W-1:0]       addr,
	input  wire logic [7:0]                      wdata,
	input  wire logic                            wr,
	input  wire logic                            rd,
	output logic      [7:0]                      rdata,
	// led drivers
	output logic      [sl_pkg::CH_N-1:0][1:0]    led_drive,
	output logic      [sl_pkg::CH_N-1:0]         led_lit,
	output logic      [sl_pkg::CH_N-1:0]         led_adv
);

	localparam int PRE_W = $clog2(TICK_CYC);
	localparam int STP_W = $clog2(sl_pkg::PWM_STEP_CYC);
	localparam logic [PRE_W-1:0] PRE_LAST = PRE_W'(TICK_CYC - 1);
	localparam logic [STP_W-1:0] STP_LAST = STP_W'(sl_pkg::PWM_STEP_CYC - 1);

	typedef struct packed {
		logic [PRE_W-1:0] pre;
		logic [STP_W-1:0] stp;
		logic [4:0]       pos;
		logic             ms_tick;
		logic [7:0]       cur1;
		logic [7:0]       bank1;
		logic [7:0]       bank2;
		logic [7:0]       adv_r;
		logic [7:0]       adv_g;
		logic [7:0]       rdata;
	} sl_top_st_t;

	sl_top_st_t st;
	sl_top_st_t next_st;

	logic [sl_pkg::CH_N-1:0][1:0] blink_v;
	logic [sl_pkg::CH_N-1:0][1:0] cur_v;
	logic [sl_pkg::CH_N-1:0][5:0] duty_v;
	logic [sl_pkg::CH_N-1:0][1:0] drive_v;
	logic [sl_pkg::CH_N-1:0]      lit_v;
	logic [7:0]                   rd_val;

	// ----------------------------------------
	// advance register write
	// ----------------------------------------
	// a write that moves the blink field from nonzero to 00 enters advance
	// mode; the duty field is then forced to full whatever was written, so a
	// later write is needed to dim the channel
	function automatic logic [7:0] adv_write(input logic [7:0] old_v,
		input logic [7:0] new_v);
		logic [7:0] res;
		res = new_v;
		if (old_v[sl_pkg::ADV_BLK +: 2] != sl_pkg::SL_BLK_NONE &&
			new_v[sl_pkg::ADV_BLK +: 2] == sl_pkg::SL_BLK_NONE) begin
			res[sl_pkg::ADV_DUTY +: 6] = sl_pkg::DUTY_FULL;
		end
		return res;
	endfunction

	// ----------------------------------------
	// per channel field decode
	// ----------------------------------------
	always_comb begin
		// red1 and green1 blink codes live in their advance registers
		blink_v[sl_pkg::CH_R1] = st.adv_r[sl_pkg::ADV_BLK +: 2];
		blink_v[sl_pkg::CH_G1] = st.adv_g[sl_pkg::ADV_BLK +: 2];
		blink_v[sl_pkg::CH_R2] = st.bank1[sl_pkg::BANK1_R2_BLK +: 2];
		blink_v[sl_pkg::CH_G2] = st.bank2[sl_pkg::BANK2_G2_BLK +: 2];
		blink_v[sl_pkg::CH_B2] = st.bank2[sl_pkg::BANK2_B2_BLK +: 2];

		cur_v[sl_pkg::CH_R1] = st.cur1[sl_pkg::CUR1_R1_CUR +: 2];
		cur_v[sl_pkg::CH_G1] = st.cur1[sl_pkg::CUR1_G1_CUR +: 2];
		cur_v[sl_pkg::CH_R2] = st.bank1[sl_pkg::BANK1_R2_CUR +: 2];
		cur_v[sl_pkg::CH_G2] = st.bank2[sl_pkg::BANK2_G2_CUR +: 2];
		cur_v[sl_pkg::CH_B2] = st.bank2[sl_pkg::BANK2_B2_CUR +: 2];

		duty_v[sl_pkg::CH_R1] = st.adv_r[sl_pkg::ADV_DUTY +: 6];
		duty_v[sl_pkg::CH_G1] = st.adv_g[sl_pkg::ADV_DUTY +: 6];
		// the second bank has no duty register here, so at no-blink it stays fully on
		duty_v[sl_pkg::CH_R2] = sl_pkg::DUTY_FULL;
		duty_v[sl_pkg::CH_G2] = sl_pkg::DUTY_FULL;
		duty_v[sl_pkg::CH_B2] = sl_pkg::DUTY_FULL;
	end

	// ----------------------------------------
	// read mux
	// ----------------------------------------
	always_comb begin
		unique case (addr)
			sl_pkg::OFS_CUR1:  rd_val = st.cur1;
			sl_pkg::OFS_BANK1: rd_val = st.bank1;
			sl_pkg::OFS_BANK2: rd_val = st.bank2;
			sl_pkg::OFS_STAT:  rd_val = {3'h0, lit_v};
			sl_pkg::OFS_ADV_R: rd_val = st.adv_r;
			sl_pkg::OFS_ADV_G: rd_val = st.adv_g;
			default:           rd_val = 8'h00;
		endcase
	end

	// ----------------------------------------
	// next state
	// ----------------------------------------
	always_comb begin
		next_st = st;

		// slow timebase for blink timing, 1 ms per tick
		next_st.ms_tick = (st.pre == PRE_LAST);
		next_st.pre = (st.pre == PRE_LAST) ? '0 : st.pre + PRE_W'(1);

		// pwm step divider; the 32 step frame is 32 us long, well above flicker
		if (st.stp == STP_LAST) begin
			next_st.stp = '0;
			next_st.pos = st.pos + 5'h01;
		end else begin
			next_st.stp = st.stp + STP_W'(1);
		end

		// read data stands for the single cycle after the strobe
		next_st.rdata = rd ? rd_val : 8'h00;

		if (wr) begin
			unique case (addr)
				sl_pkg::OFS_CUR1:  next_st.cur1 = wdata;
				sl_pkg::OFS_BANK1: next_st.bank1 = wdata;
				sl_pkg::OFS_BANK2: next_st.bank2 = wdata;
				sl_pkg::OFS_ADV_R: next_st.adv_r = adv_write(st.adv_r, wdata);
				sl_pkg::OFS_ADV_G: next_st.adv_g = adv_write(st.adv_g, wdata);
				// status and unmapped addresses ignore writes
				default: next_st.rdata = next_st.rdata;
			endcase
		end
	end

	// ----------------------------------------
	// state register
	// ----------------------------------------
	always_ff @(posedge mclk) begin
		if (!nrst) begin
			st.pre     <= '0;
			st.stp     <= '0;
			st.pos     <= '0;
			st.ms_tick <= 1'b0;
			st.cur1    <= sl_pkg::RST_CUR1;
			st.bank1   <= sl_pkg::RST_BANK1;
			st.bank2   <= sl_pkg::RST_BANK2;
			st.adv_r   <= sl_pkg::RST_ADV;
			st.adv_g   <= sl_pkg::RST_ADV;
			st.rdata   <= 8'h00;
		end else begin
			st <= next_st;
		end
	end

	// ----------------------------------------
	// channels
	// ----------------------------------------
	sl_chan_if chif [sl_pkg::CH_N] ();

	for (genvar i = 0; i < sl_pkg::CH_N; i++) begin : g_ch
		assign chif[i].blink   = blink_v[i];
		assign chif[i].cur     = cur_v[i];
		assign chif[i].duty    = duty_v[i];
		assign chif[i].ms_tick = st.ms_tick;
		assign chif[i].pwm_pos = st.pos;
		assign drive_v[i]      = chif[i].drive;
		assign lit_v[i]        = chif[i].lit;
		// advance mode is simply the blink field at no-blink
		assign led_adv[i]      = (blink_v[i] == sl_pkg::SL_BLK_NONE);

		sl_chan u_chan (
			.mclk (mclk),
			.nrst (nrst),
			.ch   (chif[i])
		);
	end

	// ----------------------------------------
	// outputs
	// ----------------------------------------
	assign rdata     = st.rdata;
	assign led_drive = drive_v;
	assign led_lit   = lit_v;

endmodule

// [sl_checker.sv]
`timescale 1ns/1ns
module sl_checker #(
	parameter int TICK_CYC = 4
) (
	// clock and reset
	input wire logic                      mclk,
	input wire logic                      nrst,
	// register port
	input wire logic [8:0]                addr,
	input wire logic [7:0]                wdata,
	input wire logic                      wr,
	input wire logic                      rd,
	input wire logic [7:0]                rdata,
	// led drivers
	input wire logic [4:0][1:0]           led_drive,
	input wire logic [4:0]                led_lit,
	input wire logic [4:0]                led_adv
);
	// ----------------------------------------
	// shadows and checks
	// ----------------------------------------
	default clocking @(posedge mclk); endclocking
	default disable iff (!nrst);
	// shadow copies tie read data and drive back to the writes
	logic [7:0] sh1;
	logic [7:0] sh2;
	logic [1:0] up;
	logic       w1;
	logic       w2;
	logic       wa;
	assign w1 = wr && addr == sl_pkg::OFS_BANK1;
	assign w2 = wr && addr == sl_pkg::OFS_BANK2;
	assign wa = wr && addr == sl_pkg::OFS_ADV_R;
	always_ff @(posedge mclk) begin
		if (!nrst) begin
			sh1 <= 8'h00;
			sh2 <= 8'h00;
			up  <= 2'h0;
		end else begin
			if (w1) sh1 <= wdata;
			if (w2) sh2 <= wdata;
			if (up != 2'h3) up <= up + 2'h1;
		end
	end
	a_rd_idle_zero: assert property (!$past(rd) |-> rdata == 8'h00)
		else $error("read data not idle");
	a_bank2_read: assert property (rd && addr == sl_pkg::OFS_BANK2 |=> rdata == $past(sh2))
		else $error("bank two readback wrong");
	a_red2_mode: assert property (w1 |=> led_adv[2] == ($past(wdata[7:6]) == 2'h0))
		else $error("red2 mode wrong");
	a_bank2_mode: assert property (w2 |=> led_adv[4:3] == {$past(wdata[7:6]) == 2'h0, $past(wdata[3:2]) == 2'h0})
		else $error("bank two mode wrong");
	a_red1_mode: assert property (wa |=> led_adv[0] == ($past(wdata[1:0]) == 2'h0))
		else $error("red1 mode wrong");
	a_red2_drive: assert property (up == 2'h3 |-> led_drive[2] == (led_lit[2] ? $past(sh1[1:0]) : 2'h0))
		else $error("red2 drive wrong");
	a_adv_full_on: assert property ($rose(led_adv[0]) |=> led_lit[0] until (wa || $past(wa)))
		else $error("advance entry not full on");
	a_red2_steady: assert property (up == 2'h3 && led_adv[2] && $past(led_adv[2]) |-> led_lit[2])
		else $error("red2 no blink not lit");
	a_blink_restart: assert property (w1 && wdata[7:6] != 2'h0 && wdata[7:6] != sh1[7:6] |-> ##2 led_lit[2])
		else $error("blink did not start lit");
	c_adv_entry: cover property ($rose(led_adv[0]));
	c_blink_off: cover property ($fell(led_lit[2]));
	c_bank2_read: cover property (rd && addr == sl_pkg::OFS_BANK2);
endmodule

// [sl_host.sv]
`timescale 1ns/1ns
module sl_host (
	// clock
	input  wire logic       mclk,
	// register port
	output logic      [8:0] addr,
	output logic      [7:0] wdata,
	output logic            wr,
	output logic            rd,
	input  wire logic [7:0] rdata
);
	initial begin
		addr  = 9'h000;
		wdata = 8'h00;
		wr    = 1'b0;
		rd    = 1'b0;
	end
	// advance registers are only touched when a caller asks; idle data is scrambled
	task automatic put(input logic [8:0] a, input logic [7:0] d);
		@(posedge mclk);
		addr  <= a;
		wdata <= d;
		wr    <= 1'b1;
		@(posedge mclk);
		wr    <= 1'b0;
		wdata <= ~d;
	endtask
	task automatic get(input logic [8:0] a, output logic [7:0] d);
		@(posedge mclk);
		addr <= a;
		rd   <= 1'b1;
		@(posedge mclk);
		rd <= 1'b0;
		#1 d = rdata;
	endtask
endmodule

// [sl_top_test.sv]
`timescale 1ns/1ns
module sl_top_test;
	// ----------------------------------------
	// bench
	// ----------------------------------------
	localparam int TICK = 2;
	logic             mclk = 1'b0;
	logic             nrst = 1'b0;
	logic [8:0]       addr;
	logic [7:0]       wdata;
	logic             wr;
	logic             rd;
	logic [7:0]       rdata;
	logic [4:0][1:0]  led_drive;
	logic [4:0]       led_lit;
	logic [4:0]       led_adv;
	logic [8:0]       ra [7] = '{9'h025, 9'h026, 9'h027, 9'h028, 9'h1d6, 9'h1d7, 9'h100};
	int               n_fail = 0;
	int               total_checks = 0;
	always #50 mclk = ~mclk;
	sl_host sl_host_i (.mclk(mclk), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata));
	sl_top #(.TICK_CYC(TICK)) sl_top_i (.mclk(mclk), .nrst(nrst), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
		.rdata(rdata), .led_drive(led_drive), .led_lit(led_lit), .led_adv(led_adv));
	task automatic close_out();
		if (n_fail == 0 && total_checks > 0) $display("NO MISMATCHES");
		else $display("MISMATCHES SEEN");
		$finish;
	endtask
	task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
		total_checks++;
		if (g !== e) begin
			n_fail++;
			$display("BAD %s exp %h got %h", nm, e, g);
		end
	endtask
	task automatic span(input int ch, input logic v, output logic [15:0] n);
		n = 16'h0;
		while (led_lit[ch] === v) begin
			n++;
			@(negedge mclk);
		end
	endtask
	// one full pwm frame; any window of that length sees the same on count
	task automatic frame(input int ch, output logic [15:0] n);
		repeat (2) @(posedge mclk);
		n = 16'h0;
		repeat (32 * sl_pkg::PWM_STEP_CYC) begin
			@(negedge mclk);
			n += 16'(led_lit[ch]);
		end
	endtask
	function automatic logic [15:0] rst_val(input logic [8:0] a);
		// status shows every channel lit: all start at no-blink with full duty
		return (a == 9'h1d6 || a == 9'h1d7) ? 16'hfc : (a == 9'h028) ? 16'h1f : 16'h0;
	endfunction
	function automatic logic [15:0] off_len(input int c);
		return 16'(((c == 1 ? 1000 : (c - 1) * 4000) - 500) * TICK);
	endfunction
	function automatic logic [15:0] duty_on(input logic [5:0] d);
		return 16'((d >= 6'h20 ? 32 : int'(d)) * sl_pkg::PWM_STEP_CYC);
	endfunction
	initial begin
		repeat (60000) @(posedge mclk);
		n_fail++;
		close_out();
	end
	initial begin
		logic [7:0]  d;
		logic [7:0]  v;
		logic [15:0] n;
		logic [8:0]  a;
		logic [31:0] r;
		logic [5:0]  dl [4];
		void'($urandom(32'h06f6));
		repeat (10) @(posedge mclk);
		nrst <= 1'b1;
		sl_host_i.put(9'h100, 8'h5a);
		chk("adv after reset", 16'h1f, 16'(led_adv));
		foreach (ra[i]) begin
			sl_host_i.get(ra[i], d);
			chk("reset value", rst_val(ra[i]), 16'(d));
		end
		for (int i = 0; i < 4; i++) begin
			r = $urandom;
			v = {r[1:0], i[1:0], r[3:2], i[1:0]};
			sl_host_i.put(9'h027, 8'h00);
			sl_host_i.put(9'h027, v);
			@(posedge mclk);
			@(negedge mclk);
			chk("bank two mode", {14'h0, v[7:6] == 2'h0, v[3:2] == 2'h0}, 16'(led_adv[4:3]));
			chk("bank two lit", 16'h3, 16'(led_lit[4:3]));
			chk("bank two drive", 16'({i[1:0], i[1:0]}), 16'(led_drive[4:3]));
			sl_host_i.get(9'h027, d);
			chk("bank two read", 16'(v), 16'(d));
		end
		sl_host_i.put(9'h025, 8'h0e);
		for (int ch = 0; ch < 2; ch++) begin
			a = 9'h1d6 + 9'(ch);
			sl_host_i.put(a, 8'h01);
			@(negedge mclk);
			chk("leave advance", 16'h0, 16'(led_adv[ch]));
			sl_host_i.put(a, 8'h14);
			sl_host_i.get(a, d);
			chk("entry duty", 16'h80, 16'(d));
			chk("adv drive", 16'(2 + ch), 16'(led_drive[ch]));
			frame(ch, n);
			chk("entry on time", duty_on(6'h20), n);
			r = $urandom;
			dl = '{6'h00, {1'b0, r[4:0]}, 6'h1f, 6'h20};
			foreach (dl[k]) begin
				sl_host_i.put(a, {dl[k], 2'h0});
				frame(ch, n);
				chk("duty on time", duty_on(dl[k]), n);
			end
		end
		for (int c = 1; c < 4; c++) begin
			sl_host_i.put(9'h026, {c[1:0], 6'h01});
			@(posedge mclk);
			@(negedge mclk);
			span(2, 1'b1, n);
			span(2, 1'b0, n);
			chk("blink off", off_len(c), n);
			span(2, 1'b1, n);
			chk("blink on", 16'(500 * TICK), n);
		end
		sl_host_i.put(9'h026, 8'h01);
		@(posedge mclk);
		@(negedge mclk);
		chk("red2 no blink", 16'h3, {14'h0, led_adv[2], led_lit[2]});
		close_out();
	end
endmodule
bind sl_top sl_checker #(.TICK_CYC(TICK_CYC)) sl_checker_i (.mclk(mclk), .nrst(nrst), .addr(addr), .wdata(wdata),
	.wr(wr), .rd(rd), .rdata(rdata), .led_drive(led_drive), .led_lit(led_lit), .led_adv(led_adv));
